// ===== rtl/smp_parser.sv
// program message parser: splits a character stream into message units
`timescale 1ns/1ps
`default_nettype none

module smp_parser
    import smp_pkg::*;
(
    // clock and reset
    input  wire logic                       core_clk_i,
    input  wire logic                       rst_b_i,
    // character stream
    input  wire logic                       char_valid_i,
    input  wire logic [7:0]                 char_i,
    // parsed message unit
    output logic                            unit_valid_o,
    output smp_node_t                       unit_node_o,
    output logic                            unit_query_o,
    output logic                            unit_common_o,
    output logic [`SMP_KW_BITS-1:0]         unit_word_o,
    output smp_pkind_t                      param_kind_o,
    output logic [`SMP_PARAM_BITS-1:0]      param_data_o,
    output logic [`SMP_KW_LEN_W-1:0]        param_len_o,
    // message events and status
    output logic                            msg_end_o,
    output logic                            error_o,
    output logic [`SMP_ERRCNT_W-1:0]        error_count_o,
    output smp_node_t                       tree_node_o
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    smp_state_t                  state;
    smp_state_t                  next_state;
    smp_node_t                   tree;
    smp_node_t                   unit_base;
    smp_node_t                   last_node;
    logic [`SMP_KW_BITS-1:0]     word_buf;
    logic [`SMP_KW_LEN_W-1:0]    word_len;
    logic                        common;
    logic                        query;
    logic [`SMP_PARAM_BITS-1:0]  param_buf;
    logic [`SMP_KW_LEN_W-1:0]    param_len;
    smp_pkind_t                  pkind;
    logic [`SMP_ERRCNT_W-1:0]    err_cnt;

    // decisions for the current character
    logic err_now;
    logic unit_end;
    logic msg_end;
    logic word_clr;
    logic word_push;
    logic node_take;
    logic tree_desc;
    logic tree_root;
    logic tree_restore;
    logic set_query;
    logic set_common;
    logic param_first;
    logic param_push;

    // character classes
    logic [7:0] up_ch;
    logic       is_alpha;
    logic       is_num;
    logic       is_lf;
    logic       is_semi;
    logic       is_colon;
    logic       is_query;
    logic       is_space;
    logic       is_star;
    logic       is_term;

    smp_kw_if kw ();

    ////////////////////////////////////////////////////////////////////////////
    // classification and keyword lookup
    smp_char_class u_class (
        .char_i      (char_i),
        .upper_o     (up_ch),
        .alpha_o     (is_alpha),
        .num_start_o (is_num)
    );

    smp_kw_match #(
        .NUM_NODES (`SMP_NUM_NODES)
    ) u_match (
        .kw (kw.matcher)
    );

    assign kw.word = word_buf;
    assign kw.len  = word_len;
    assign kw.base = tree;

    assign is_lf    = (char_i == `SMP_CH_LF);
    assign is_semi  = (char_i == `SMP_CH_SEMI);
    assign is_colon = (char_i == `SMP_CH_COLON);
    assign is_query = (char_i == `SMP_CH_QUERY);
    assign is_space = (char_i == `SMP_CH_SPACE);
    assign is_star  = (char_i == `SMP_CH_STAR);
    assign is_term  = is_lf || is_semi;

    ////////////////////////////////////////////////////////////////////////////
    // per-character decision
    always_comb
    begin
        next_state   = state;
        err_now      = 1'b0;
        unit_end     = 1'b0;
        msg_end      = 1'b0;
        word_clr     = 1'b0;
        word_push    = 1'b0;
        node_take    = 1'b0;
        tree_desc    = 1'b0;
        tree_root    = 1'b0;
        tree_restore = 1'b0;
        set_query    = 1'b0;
        set_common   = 1'b0;
        param_first  = 1'b0;
        param_push   = 1'b0;
        if (char_valid_i)
        begin
            case (state)
                ST_START:
                begin
                    if (is_colon)
                    begin
                        tree_root  = 1'b1;
                        next_state = ST_SEP;
                    end
                    else if (is_star)
                    begin
                        set_common = 1'b1;
                        word_clr   = 1'b1;
                        next_state = ST_KW;
                    end
                    else if (is_alpha)
                    begin
                        word_clr   = 1'b1;
                        word_push  = 1'b1;
                        next_state = ST_KW;
                    end
                    else if (!(is_space || is_term))
                        err_now = 1'b1;
                end
                ST_SEP:
                begin
                    if (is_alpha)
                    begin
                        word_clr   = 1'b1;
                        word_push  = 1'b1;
                        next_state = ST_KW;
                    end
                    else
                        err_now = 1'b1;
                end
                ST_KW:
                begin
                    if (is_alpha)
                    begin
                        if (word_len == 4'(`SMP_KW_MAX))
                            err_now = 1'b1;
                        else
                            word_push = 1'b1;
                    end
                    else if (is_colon || is_query || is_space || is_term)
                    begin
                        if (!common && !kw.hit)
                            err_now = 1'b1;
                        else if (common && is_colon)
                            err_now = 1'b1;
                        else
                        begin
                            node_take = !common;
                            if (is_colon)
                            begin
                                tree_desc  = 1'b1;
                                next_state = ST_SEP;
                            end
                            else if (is_query)
                            begin
                                set_query  = 1'b1;
                                next_state = ST_QRY;
                            end
                            else if (is_space)
                                next_state = ST_PWAIT;
                            else
                                unit_end = 1'b1;
                        end
                    end
                    else
                        err_now = 1'b1;
                end
                ST_QRY:
                begin
                    if (is_space)
                        next_state = ST_PWAIT;
                    else if (is_term)
                        unit_end = 1'b1;
                    else
                        err_now = 1'b1;
                end
                ST_PWAIT:
                begin
                    // only one space; data must follow it
                    if (is_space || is_term)
                        err_now = 1'b1;
                    else
                    begin
                        param_first = 1'b1;
                        next_state  = ST_PARAM;
                    end
                end
                ST_PARAM:
                begin
                    if (is_term)
                        unit_end = 1'b1;
                    else if (is_space)
                        err_now = 1'b1;
                    else
                        param_push = 1'b1;
                end
                ST_DROP:
                begin
                    next_state = ST_DROP;
                end
                default:
                begin
                    next_state = ST_START;
                end
            endcase
            if (err_now)
            begin
                next_state = ST_DROP;
                unit_end   = 1'b0;
            end
            if (is_term)
            begin
                next_state = ST_START;
                if (is_lf)
                begin
                    msg_end   = 1'b1;
                    tree_root = 1'b1;
                end
                else if (err_now || (state == ST_DROP))
                    tree_restore = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencing
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            state <= ST_START;
        else
            state <= next_state;
    end

    // tree position; a clean semicolon keeps the level of the last keyword
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            tree <= `SMP_NODE_ROOT;
        else if (tree_root)
            tree <= `SMP_NODE_ROOT;
        else if (tree_restore)
            tree <= unit_base;
        else if (tree_desc)
            tree <= kw.node;
    end

    // level in force when the unit began, for restoring after a drop
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            unit_base <= `SMP_NODE_ROOT;
        else if (state == ST_START)
            unit_base <= tree;
    end

    ////////////////////////////////////////////////////////////////////////////
    // keyword buffer, stored upper case
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            word_buf <= '0;
            word_len <= '0;
        end
        else if (word_clr)
        begin
            word_buf <= word_push ? {up_ch, 88'h0} : '0;
            word_len <= word_push ? 4'h1 : 4'h0;
        end
        else if (word_push)
        begin
            word_buf[8*(`SMP_KW_MAX-1-int'(word_len)) +: 8] <= up_ch;
            word_len <= word_len + 4'h1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            last_node <= `SMP_NODE_ROOT;
        else if (node_take)
            last_node <= kw.node;
    end

    // unit flags
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            common <= 1'b0;
            query  <= 1'b0;
        end
        else if (state == ST_START)
        begin
            common <= set_common;
            query  <= 1'b0;
        end
        else if (set_query)
            query <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // data parameter
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            param_buf <= '0;
            param_len <= '0;
            pkind     <= PK_NONE;
        end
        else if (state == ST_START)
        begin
            param_buf <= '0;
            param_len <= '0;
            pkind     <= PK_NONE;
        end
        else if (param_first)
        begin
            param_buf <= {char_i, 56'h0};
            param_len <= 4'h1;
            pkind     <= is_num ? PK_NUMERIC : PK_STRING;
        end
        else if (param_push && (param_len < 4'(`SMP_PARAM_MAX)))
        begin
            param_buf[8*(`SMP_PARAM_MAX-1-int'(param_len)) +: 8] <= char_i;
            param_len <= param_len + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // unit output
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            unit_valid_o  <= 1'b0;
            unit_node_o   <= `SMP_NODE_ROOT;
            unit_query_o  <= 1'b0;
            unit_common_o <= 1'b0;
            unit_word_o   <= '0;
            param_kind_o  <= PK_NONE;
            param_data_o  <= '0;
            param_len_o   <= '0;
        end
        else
        begin
            unit_valid_o <= unit_end;
            if (unit_end)
            begin
                unit_node_o   <= common ? `SMP_NODE_ROOT : (node_take ? kw.node : last_node);
                unit_query_o  <= query;
                unit_common_o <= common;
                unit_word_o   <= word_buf;
                param_kind_o  <= pkind;
                param_data_o  <= param_buf;
                param_len_o   <= param_len;
            end
        end
    end

    // message end and errors
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            msg_end_o <= 1'b0;
            error_o   <= 1'b0;
            err_cnt   <= '0;
        end
        else
        begin
            msg_end_o <= msg_end;
            error_o   <= err_now;
            if (err_now && (err_cnt != `SMP_ERRCNT_MAX))
                err_cnt <= err_cnt + 8'h01;
        end
    end

    assign error_count_o = err_cnt;
    assign tree_node_o   = tree;

endmodule : smp_parser

`default_nettype wire

// ===== rtl/smp_defs.svh
// constants for the program message parser
`ifndef SMP_DEFS_SVH
`define SMP_DEFS_SVH

// character codes
`define SMP_CH_LF     8'h0A
`define SMP_CH_SPACE  8'h20
`define SMP_CH_STAR   8'h2A
`define SMP_CH_PLUS   8'h2B
`define SMP_CH_MINUS  8'h2D
`define SMP_CH_DOT    8'h2E
`define SMP_CH_COLON  8'h3A
`define SMP_CH_SEMI   8'h3B
`define SMP_CH_QUERY  8'h3F
`define SMP_CH_LOW_A  8'h61
`define SMP_CH_LOW_Z  8'h7A
`define SMP_CH_UP_A   8'h41
`define SMP_CH_UP_Z   8'h5A
`define SMP_CH_DIG_0  8'h30
`define SMP_CH_DIG_9  8'h39
`define SMP_CASE_DIFF 8'h20

// keyword and parameter buffers
`define SMP_KW_MAX     12
`define SMP_KW_LEN_W   4
`define SMP_KW_BITS    96
`define SMP_PARAM_MAX  8
`define SMP_PARAM_BITS 64

// short form derivation
`define SMP_SHORT_WHOLE 4
`define SMP_SHORT_VOWEL 3

// command tree
`define SMP_NODE_W    5
`define SMP_NUM_NODES 28
`define SMP_NODE_ROOT 5'h00
`define SMP_NODE_NONE 5'h1F

// counters
`define SMP_ERRCNT_W   8
`define SMP_ERRCNT_MAX 8'hFF

`endif

// ===== rtl/smp_pkg.sv
// types shared by the program message parser
`include "smp_defs.svh"

package smp_pkg;

    typedef logic [`SMP_NODE_W-1:0] smp_node_t;

    typedef enum {
        ST_START,
        ST_SEP,
        ST_KW,
        ST_QRY,
        ST_PWAIT,
        ST_PARAM,
        ST_DROP
    } smp_state_t;

    typedef enum logic [1:0] {
        PK_NONE,
        PK_NUMERIC,
        PK_STRING
    } smp_pkind_t;

endpackage : smp_pkg

// ===== rtl/smp_kw_if.sv
// keyword lookup carrier between parser and matcher
`timescale 1ns/1ps
`default_nettype none

interface smp_kw_if;
    import smp_pkg::*;

    logic [`SMP_KW_BITS-1:0]  word;
    logic [`SMP_KW_LEN_W-1:0] len;
    smp_node_t                base;
    logic                     hit;
    smp_node_t                node;

    modport parser  (output word, len, base, input  hit, node);
    modport matcher (input  word, len, base, output hit, node);
endinterface : smp_kw_if

`default_nettype wire

// ===== rtl/smp_char_class.sv
// character classifier with case folding
`timescale 1ns/1ps
`default_nettype none

module smp_char_class
    import smp_pkg::*;
(
    // raw character
    input  wire logic [7:0] char_i,
    // classes
    output logic      [7:0] upper_o,
    output logic            alpha_o,
    output logic            num_start_o
);

    logic is_low;
    logic is_digit;

    assign is_low      = (char_i >= `SMP_CH_LOW_A) && (char_i <= `SMP_CH_LOW_Z);
    assign is_digit    = (char_i >= `SMP_CH_DIG_0) && (char_i <= `SMP_CH_DIG_9);
    assign upper_o     = is_low ? (char_i - `SMP_CASE_DIFF) : char_i;
    assign alpha_o     = is_low || ((char_i >= `SMP_CH_UP_A) && (char_i <= `SMP_CH_UP_Z));
    assign num_start_o = is_digit || (char_i == `SMP_CH_PLUS) || (char_i == `SMP_CH_MINUS)
                         || (char_i == `SMP_CH_DOT);

endmodule : smp_char_class

`default_nettype wire

// ===== rtl/smp_kw_match.sv
// command tree table and keyword matcher
`timescale 1ns/1ps
`default_nettype none

module smp_kw_match
    import smp_pkg::*;
#(
    parameter int NUM_NODES = `SMP_NUM_NODES
)
(
    smp_kw_if.matcher kw
);

    typedef logic [`SMP_KW_BITS-1:0] name_t;

    // tree: long form names, parent node, optional flag
    localparam name_t NAME [NUM_NODES] = '{
        96'h0, "ABORT", "CALIBRATE", "DISPLAY", "INITIATE", "LIST", "MEASURE", "OUTPUT",
        "SOURCE", "STATUS", "SYSTEM", "TRIGGER", "VOLTAGE", "CURRENT", "FUNCTION",
        "LEVEL", "LEVEL", "IMMEDIATE", "IMMEDIATE", "STATE", "OPERATION", "PRESET",
        "QUESTIONABLE", "CONDITION", "ENABLE", "SCALAR", "VOLTAGE", "CURRENT"
    };
    localparam smp_node_t PARENT [NUM_NODES] = '{
        5'h1F, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00,
        5'h00, 5'h00, 5'h00, 5'h00, 5'h08, 5'h08, 5'h08,
        5'h0C, 5'h0D, 5'h0F, 5'h10, 5'h07, 5'h09, 5'h09,
        5'h09, 5'h14, 5'h14, 5'h06, 5'h19, 5'h19
    };
    localparam logic OPT [NUM_NODES] = '{
        1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
        1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
        1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0,
        1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0
    };

    // move the printable text to the top bytes
    function automatic name_t ljust(input name_t s);
        name_t r;
        r = s;
        for (int k = 0; k < `SMP_KW_MAX; k++)
        begin
            if ((r != '0) && (r[`SMP_KW_BITS-1 -: 8] == 8'h00))
                r = r << 8;
        end
        return r;
    endfunction : ljust

    function automatic logic [`SMP_KW_LEN_W-1:0] long_len(input name_t s);
        logic [`SMP_KW_LEN_W-1:0] n;
        n = '0;
        for (int k = 0; k < `SMP_KW_MAX; k++)
        begin
            if (s[8*k +: 8] != 8'h00)
                n = n + 4'h1;
        end
        return n;
    endfunction : long_len

    function automatic logic is_vowel(input logic [7:0] c);
        return (c == "A") || (c == "E") || (c == "I") || (c == "O") || (c == "U");
    endfunction : is_vowel

    logic [NUM_NODES-1:0] hit_vec;
    name_t                mask;

    assign mask = ~({`SMP_KW_BITS{1'b1}} >> (8 * int'(kw.len)));

    for (genvar i = 0; i < NUM_NODES; i++)
    begin : g_node
        localparam name_t                    NM    = ljust(NAME[i]);
        localparam logic [`SMP_KW_LEN_W-1:0] LLEN  = long_len(NM);
        // short form: whole word up to four letters, else three or four
        localparam logic [`SMP_KW_LEN_W-1:0] SLEN  = (LLEN <= 4'(`SMP_SHORT_WHOLE)) ? LLEN :
            (is_vowel(NM[`SMP_KW_BITS-25 -: 8]) ? 4'(`SMP_SHORT_VOWEL) : 4'(`SMP_SHORT_WHOLE));
        // a skipped optional parent lets the child match one level up
        // root entry has no parent; point it at itself to keep table lookups in range
        localparam int                       PIDX  = (i == 0) ? 0 : int'(PARENT[i]);
        localparam smp_node_t                ALT   = OPT[PIDX] ? PARENT[PIDX] : `SMP_NODE_NONE;
        logic at_level;
        logic len_ok;
        assign at_level   = (kw.base == PARENT[i]) || (kw.base == ALT);
        assign len_ok     = (kw.len != '0) && ((kw.len == SLEN) || (kw.len == LLEN));
        assign hit_vec[i] = (i != 0) && at_level && len_ok && (kw.word == (NM & mask));
    end

    always_comb
    begin
        kw.hit  = 1'b0;
        kw.node = `SMP_NODE_ROOT;
        for (int i = NUM_NODES - 1; i > 0; i--)
        begin
            if (hit_vec[i])
            begin
                kw.hit  = 1'b1;
                kw.node = 5'(i);
            end
        end
    end

endmodule : smp_kw_match

`default_nettype wire

// ===== testbench/smp_parser_assertions.sv
// assertions on the message parser ports
`timescale 1ns/1ps
`default_nettype none
`include "smp_defs.svh"
module smp_parser_assertions
    import smp_pkg::*;
(
    // clock, reset, stream
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic char_valid_i,
    input wire logic [7:0] char_i,
    // unit and status
    input wire logic unit_valid_o,
    input wire smp_node_t unit_node_o,
    input wire logic unit_common_o,
    input wire smp_pkind_t param_kind_o,
    input wire logic [`SMP_PARAM_BITS-1:0] param_data_o,
    input wire logic [`SMP_KW_LEN_W-1:0] param_len_o,
    input wire logic msg_end_o,
    input wire logic error_o,
    input wire smp_node_t tree_node_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    wire lf_in = char_valid_i && char_i == `SMP_CH_LF;
    wire sep_in = lf_in || (char_valid_i && char_i == `SMP_CH_SEMI);
    lf_ends_msg_a: assert property (lf_in |=> msg_end_o)
        else $error("line feed did not end message");
    end_only_lf_a: assert property (msg_end_o |-> $past(lf_in))
        else $error("message end without line feed");
    lf_root_a: assert property (lf_in |=> tree_node_o == `SMP_NODE_ROOT)
        else $error("tree not at root after line feed");
    unit_sep_a: assert property (unit_valid_o |-> $past(sep_in))
        else $error("unit without separator");
    common_node_a: assert property (unit_valid_o && unit_common_o |-> unit_node_o == 0)
        else $error("common unit has tree node");
    error_drop_a: assert property (error_o |-> !unit_valid_o)
        else $error("rejected unit emitted");
    node_range_a: assert property (unit_valid_o && !unit_common_o |->
        unit_node_o != 0 && unit_node_o < `SMP_NUM_NODES) else $error("unit node out of tree");
    num_param_a: assert property (unit_valid_o && param_kind_o == PK_NUMERIC |->
        param_data_o[63:56] inside {[`SMP_CH_DIG_0:`SMP_CH_DIG_9], `SMP_CH_PLUS, `SMP_CH_MINUS, `SMP_CH_DOT})
        else $error("numeric parameter bad lead");
    no_param_a: assert property (unit_valid_o && param_kind_o == PK_NONE |-> param_len_o == 0)
        else $error("parameter length without kind");
endmodule : smp_parser_assertions
bind smp_parser smp_parser_assertions u_chk (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .char_valid_i(char_valid_i), .char_i(char_i), .unit_valid_o(unit_valid_o), .unit_node_o(unit_node_o),
    .unit_common_o(unit_common_o), .param_kind_o(param_kind_o), .param_data_o(param_data_o),
    .param_len_o(param_len_o), .msg_end_o(msg_end_o), .error_o(error_o), .tree_node_o(tree_node_o));
`default_nettype wire

// ===== testbench/smp_ctrl_model.sv
// controller model sending program messages
`timescale 1ns/1ps
`default_nettype none
`include "smp_defs.svh"
module smp_ctrl_model
(
    // clock
    input  wire logic       core_clk_i,
    // character stream
    output var  logic       char_valid_o,
    output var  logic [7:0] char_o
);
    initial
    begin
        char_valid_o = 1'b0;
        char_o = 8'h00;
    end
    // idle cycles invert the previous char_o; the final idle of a slow send restores the line feed
    task automatic send(input string s, input bit slow);
        for (int i = 0; i <= s.len(); i++)
        begin
            @(negedge core_clk_i);
            char_valid_o = 1'b1;
            char_o = (i < s.len()) ? s[i] : `SMP_CH_LF;
            if (slow)
            begin
                @(negedge core_clk_i);
                char_valid_o = 1'b0;
                char_o = ~char_o;
            end
        end
        @(negedge core_clk_i);
        char_valid_o = 1'b0;
        char_o = ~char_o;
    endtask : send
endmodule : smp_ctrl_model
`default_nettype wire

// ===== testbench/scpi_message_parser_tb.sv
// self-checking bench for the program message parser
`timescale 1ns/1ps
`default_nettype none
`include "smp_defs.svh"
module scpi_message_parser_tb
    import smp_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic char_valid_i, unit_valid_o, unit_query_o, unit_common_o, msg_end_o, error_o;
    logic [7:0] char_i;
    smp_node_t unit_node_o, tree_node_o;
    smp_pkind_t param_kind_o;
    logic [`SMP_KW_BITS-1:0] unit_word_o;
    logic [`SMP_PARAM_BITS-1:0] param_data_o;
    logic [`SMP_KW_LEN_W-1:0] param_len_o;
    logic [`SMP_ERRCNT_W-1:0] error_count_o;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    smp_node_t nq[$];
    logic qq[$];
    smp_node_t roots[10] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0A, 5'h0B};
    smp_parser DUT (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .char_valid_i(char_valid_i), .char_i(char_i),
        .unit_valid_o(unit_valid_o), .unit_node_o(unit_node_o), .unit_query_o(unit_query_o),
        .unit_common_o(unit_common_o), .unit_word_o(unit_word_o), .param_kind_o(param_kind_o),
        .param_data_o(param_data_o), .param_len_o(param_len_o), .msg_end_o(msg_end_o), .error_o(error_o),
        .error_count_o(error_count_o), .tree_node_o(tree_node_o));
    smp_ctrl_model u_ctl (.core_clk_i(core_clk_i), .char_valid_o(char_valid_i), .char_o(char_i));
    initial
        forever #2 core_clk_i = ~core_clk_i;
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            errors++;
            stop_test();
        end
        if (unit_valid_o === 1'b1)
        begin
            nq.push_back(unit_node_o);
            qq.push_back(unit_query_o);
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic run(input string s, input int n, input bit slow);
        nq.delete();
        qq.delete();
        u_ctl.send(s, slow);
        repeat (3) @(posedge core_clk_i);
        chk(nq.size(), n);
    endtask : run
    task automatic pop(input smp_node_t n, input logic q);
        chk(nq.pop_front(), n);
        chk(qq.pop_front(), q);
    endtask : pop
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_params();
        run("VOLT 5", 1, 0);
        pop(5'h0C, 1'b0);
        chk(param_kind_o, PK_NUMERIC);
        chk(param_data_o[63:56], 8'h35);
        run("OUTP ON", 1, 1);
        pop(5'h07, 1'b0);
        chk(param_kind_o, PK_STRING);
        chk(param_len_o, 4'h2);
    endtask : t_params
    task automatic t_tree();
        run("meas:volt?;curr?", 2, 0);
        pop(5'h1A, 1'b1);
        pop(5'h1B, 1'b1);
        chk(unit_word_o[95:64], 32'h43555252);
        run("VoLtAgE:LEV 6;:CURR:LEV 15", 2, 0);
        pop(5'h0F, 1'b0);
        pop(5'h10, 1'b0);
        run("STAT:OPER:COND?;ENAB 16", 2, 0);
        pop(5'h17, 1'b1);
        pop(5'h18, 1'b0);
        run("MEASURE:SCALAR:CURRENT?", 1, 0);
        pop(5'h1B, 1'b1);
        run(":SOUR:FUNC;VOLT?", 2, 0);
        pop(5'h0E, 1'b0);
        pop(5'h0C, 1'b1);
        chk(tree_node_o, 5'h00);
    endtask : t_tree
    task automatic t_root();
        run("ABOR;CAL;DISP;INIT;LIST;MEAS;OUTP;STAT;SYST;TRIG", 10, 0);
        foreach (roots[i])
            pop(roots[i], 1'b0);
    endtask : t_root
    task automatic t_errors();
        run("*RST", 1, 0);
        pop(5'h00, 1'b0);
        chk(unit_common_o, 1'b1);
        chk(unit_word_o[95:64], 32'h52535400);
        run("MEAS:VOLTA", 0, 0);
        run("VOLT:LEV:IMME 1", 0, 0);
        run("CURR\015", 0, 0);
        chk(error_count_o, 8'h03);
        chk(unit_common_o, 1'b1);
        chk(tree_node_o, 5'h00);
    endtask : t_errors
    task automatic stop_test();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (16) @(posedge core_clk_i);
        @(negedge core_clk_i);
        rst_b_i = 1'b1;
        t_params();
        t_tree();
        t_root();
        t_errors();
        stop_test();
    end
endmodule : scpi_message_parser_tb
`default_nettype wire
